// *** ers_pkg.sv ***
/*
 * Constants, register map and types of the supervisor.
 * Assumes a 125 MHz clock and 32-bit AXI4-Lite access.
 */
package ers_pkg;

    // Clock and the ramp / retry time base
    localparam int          CLK_PERIOD_NS = 8;
    localparam int          TICK_TIME_NS  = 1000000;
    localparam int          TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

    // Terminals, faults, function code
    localparam int          NUM_TERM      = 5;
    localparam int          NUM_FAULT     = 18;
    localparam int          FN_W          = 6;
    localparam logic [5:0]  FUNC_EMERG    = 6'h33;

    // Mode selection values
    localparam logic [1:0]  MODE_OFF      = 2'h0;
    localparam logic [1:0]  MODE_ACTIVE   = 2'h1;
    localparam logic [1:0]  MODE_TRIAL    = 2'h2;

    // Register byte offsets
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_TERMFN   = 8'h04;
    localparam logic [7:0]  ADDR_FREQ     = 8'h08;
    localparam logic [7:0]  ADDR_ACC      = 8'h0C;
    localparam logic [7:0]  ADDR_DEC      = 8'h10;
    localparam logic [7:0]  ADDR_RETRY    = 8'h14;
    localparam logic [7:0]  ADDR_STATUS   = 8'h18;
    localparam logic [7:0]  ADDR_COUNT    = 8'h1C;
    localparam logic [7:0]  ADDR_HIST     = 8'h20;

    // Field positions
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_DIR_BIT  = 2;

    // Reset values
    localparam logic [1:0]  MODE_RST      = 2'h0;
    localparam logic        DIR_RST       = 1'h0;
    localparam logic [29:0] TERMFN_RST    = 30'h0;
    localparam logic [6:0]  FREQ_MAX      = 7'h3C;
    localparam logic [6:0]  FREQ_RST      = 7'h3C;
    localparam logic [15:0] ACC_RST       = 16'h0064;
    localparam logic [15:0] DEC_RST       = 16'h0064;
    localparam logic [15:0] RETRY_RST     = 16'h03E8;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Fault classes: bits 0..12 ignored, 13..15 restarted, 16..17 stopping
    localparam logic [17:0] FAULT_IGN     = 18'h01FFF;
    localparam logic [17:0] FAULT_RESTART = 18'h0E000;
    localparam logic [17:0] FAULT_STOP    = 18'h30000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_RUN   = 3'h1,
        ST_DECEL = 3'h2,
        ST_RETRY = 3'h3,
        ST_HALT  = 3'h4
    } ers_state_type;

endpackage

// *** ers_ramp_if.sv ***
/*
 * Supervisor to ramp link.
 * Assumes one clock.
 */
`timescale 1ns/1ps
interface ers_ramp_if;
    logic        tick;
    logic        drop;
    logic [6:0]  target;
    logic [15:0] acc_time;
    logic [15:0] dec_time;
    logic [6:0]  level;
    logic        at_target;
    modport ctrl (output tick, drop, target, acc_time, dec_time, input level, at_target);
    modport ramp (input tick, drop, target, acc_time, dec_time, output level, at_target);
endinterface

// *** ers_ramp.sv ***
/*
 * Frequency ramp: one 1 Hz step per acc or dec time in ticks.
 * Assumes tick is a one-cycle divider enable.
 */
`timescale 1ns/1ps
module ers_ramp import ers_pkg::*; (
    input  wire logic clk,
    input  wire logic rst_n,
    ers_ramp_if.ramp  rp
);
    typedef struct packed {
        logic [6:0]  level;
        logic [15:0] cnt;
    } ers_ramp_state_type;

    ers_ramp_state_type r;
    ers_ramp_state_type next_r;
    logic               up;
    logic [15:0]        step_time;

    always_comb begin
        next_r    = r;
        up        = rp.target > r.level;
        step_time = up ? rp.acc_time : rp.dec_time;
        if (rp.drop) begin
            next_r = '0;
        end else if (r.level == rp.target) begin
            next_r.cnt = '0;
        end else if (rp.tick) begin
            // Zero time steps on every tick
            if (r.cnt + 16'h1 >= step_time) begin
                next_r.cnt   = '0;
                next_r.level = up ? r.level + 7'h1 : r.level - 7'h1;
            end else begin
                next_r.cnt = r.cnt + 16'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign rp.level     = r.level;
    assign rp.at_target = r.level == rp.target;

endmodule // ers_ramp

// *** ers_sync.sv ***
/*
 * Three-stage pin synchroniser; stages two and three must agree.
 * Assumes asynchronous pins.
 */
`timescale 1ns/1ps
module ers_sync #(
    parameter int N = 5
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] level_out
);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic [N-1:0] q;
    } ers_sync_state_type;

    ers_sync_state_type r;
    ers_sync_state_type next_r;
    logic [N-1:0]       accepted;

    for (genvar i = 0; i < N; i++) begin : g_bit
        assign accepted[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
    end

    always_comb begin
        next_r    = r;
        next_r.s1 = pin_in;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.q  = accepted;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level_out = r.q;

endmodule // ers_sync

// *** ers_supervisor.sv ***
/*
 * Emergency-run supervisor: entry, overrides,
 * fault classes, retry timing, registers.
 * Assumes fault_in and normal references on clk;
 * terminal pins asynchronous.
 */
// What this block does
// (RQ1) Active mode and code-51 terminal on: enter run, count plus one.
// (RQ2) Trial mode runs without auto restart or count.
// (RQ3) Set frequency overrides other sources in run; 0 to 60, default 60.
// (RQ4) Direction comes from the one-bit setting.
// (RQ5) Entry ramps up with the acceleration time.
// (RQ6) Terminal off: decelerate with the deceleration time until stopped.
// (RQ7) Ignored faults reach history; trip output stays off.
// (RQ8) Minor, external, stop-input, voltage, thermal, phase, fan faults ignored.
// (RQ9) Over-voltage, level-one over-current, ground fault: restart until clear.
// (RQ10) Restart attempts are unlimited.
// (RQ11) Retry delay between restart attempts.
// (RQ12) Self-diagnosis or arm-short fault stops the drive.
// (RQ13) Entry counter is read-only.
`timescale 1ns/1ps
module ers_supervisor import ers_pkg::*; #(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [4:0]  multifunction_input_terminal,
    input  wire logic [17:0] fault_in,
    input  wire logic [6:0]  normal_freq,
    input  wire logic        normal_dir,
    input  wire logic        normal_run,
    output logic [6:0]       freq_ref,
    output logic             run_dir,
    output logic             run_enable,
    output logic             emerg_active,
    output logic             trip_out,
    output logic             fault_reset,
    output logic             fault_record
);
    typedef struct packed {
        ers_state_type st;
        logic [1:0]    mode;
        logic          dir;
        logic [29:0]   termfn;
        logic [6:0]    freq;
        logic [15:0]   acc;
        logic [15:0]   dec;
        logic [15:0]   retry;
        logic [15:0]   count;
        logic [17:0]   hist;
        logic [17:0]   fault_q;
        logic          req_q;
        logic [16:0]   tick_cnt;
        logic          tick;
        logic [15:0]   dly;
        logic          aw_got;
        logic [7:0]    aw_addr;
        logic          w_got;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
        logic          reset_p;
        logic          rec_p;
        logic [6:0]    out_freq;
        logic          out_dir;
        logic          out_run;
        logic          out_trip;
    } ers_state_pack_type;

    ers_state_pack_type r;
    ers_state_pack_type next_r;

    ers_ramp_if          rif ();
    logic [4:0]          term_lvl;
    logic [NUM_TERM-1:0] term_hit;
    logic                term_on;
    logic                mode_on;
    logic                trial;
    logic                req;
    logic                enter;
    logic [17:0]         f_rst;
    logic [17:0]         f_stop;
    logic [17:0]         f_rise;
    logic                aw_take;
    logic                w_take;
    logic                ar_take;
    logic                active;
    logic [32:0]         wr_old;
    logic [32:0]         rd_val;
    logic [31:0]         bmask;
    logic [31:0]         wv;

    ers_sync #(
        .N (NUM_TERM)
    ) u_sync (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (multifunction_input_terminal),
        .level_out (term_lvl)
    );

    ers_ramp u_ramp (
        .clk   (clk),
        .rst_n (rst_n),
        .rp    (rif.ramp)
    );

    // Bit 32 marks a mapped offset
    function automatic logic [32:0] reg_view(input logic [7:0] a, input ers_state_pack_type s);
        logic [32:0] v;
        v = {1'b1, 32'h0};
        case (a)
            ADDR_CTRL: begin
                v[31:0] = {29'h0, s.dir, s.mode};
            end
            ADDR_TERMFN: begin
                v[31:0] = {2'h0, s.termfn};
            end
            ADDR_FREQ: begin
                v[31:0] = {25'h0, s.freq};
            end
            ADDR_ACC: begin
                v[31:0] = {16'h0, s.acc};
            end
            ADDR_DEC: begin
                v[31:0] = {16'h0, s.dec};
            end
            ADDR_RETRY: begin
                v[31:0] = {16'h0, s.retry};
            end
            ADDR_STATUS: begin
                v[31:0] = {19'h0, s.out_freq, s.out_run, s.out_trip, s.req_q, s.st};
            end
            ADDR_COUNT: begin
                v[31:0] = {16'h0, s.count};
            end
            ADDR_HIST: begin
                v[31:0] = {14'h0, s.hist};
            end
            default: begin
                v = '0;
            end
        endcase
        return v;
    endfunction

    // (RQ1) function-51 terminals
    for (genvar i = 0; i < NUM_TERM; i++) begin : g_term
        assign term_hit[i] = term_lvl[i] && (r.termfn[FN_W*i +: FN_W] == FUNC_EMERG);
    end

    assign term_on = |term_hit;
    assign trial   = r.mode == MODE_TRIAL;
    assign mode_on = (r.mode == MODE_ACTIVE) || trial;
    assign req     = mode_on && term_on;
    assign enter   = req && !r.req_q;
    assign f_rst   = fault_in & FAULT_RESTART;
    assign f_stop  = fault_in & FAULT_STOP;
    assign f_rise  = fault_in & ~r.fault_q;
    assign active  = r.st != ST_IDLE;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign bmask[8*b +: 8] = {8{r.wstrb[b]}};
    end

    assign wr_old = reg_view(r.aw_addr, r);
    assign rd_val = reg_view(s_axi_araddr, r);
    assign wv     = (wr_old[31:0] & ~bmask) | (r.wdata & bmask);

    always_comb begin
        next_r         = r;
        next_r.reset_p = 1'b0;
        next_r.tick    = 1'b0;
        next_r.req_q   = req;
        next_r.fault_q = fault_in;

        // Tick divider
        if (r.tick_cnt >= 17'(TICK_LEN - 1)) begin
            next_r.tick_cnt = '0;
            next_r.tick     = 1'b1;
        end else begin
            next_r.tick_cnt = r.tick_cnt + 17'h1;
        end

        // Bus write: address and data in either order
        if (aw_take) begin
            next_r.aw_got  = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            next_r.w_got = 1'b1;
            next_r.wdata = s_axi_wdata;
            next_r.wstrb = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        if (r.aw_got && r.w_got && !r.bvalid) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = wr_old[32] ? RESP_OKAY : RESP_SLVERR;
            case (r.aw_addr)
                ADDR_CTRL: begin
                    next_r.mode = wv[CTRL_MODE_LSB +: 2];
                    next_r.dir  = wv[CTRL_DIR_BIT];
                end
                ADDR_TERMFN: begin
                    next_r.termfn = wv[29:0];
                end
                // (RQ3) frequency limit
                ADDR_FREQ: begin
                    next_r.freq = (wv[6:0] > FREQ_MAX) ? FREQ_MAX : wv[6:0];
                end
                ADDR_ACC: begin
                    next_r.acc = wv[15:0];
                end
                ADDR_DEC: begin
                    next_r.dec = wv[15:0];
                end
                ADDR_RETRY: begin
                    next_r.retry = wv[15:0];
                end
                ADDR_HIST: begin
                    next_r.hist = r.hist & ~(r.wdata[17:0] & bmask[17:0]);
                end
                // (RQ13) counter not writable
                default: begin
                    next_r.count = r.count;
                end
            endcase
        end

        // Bus read
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (ar_take) begin
            next_r.rvalid = 1'b1;
            next_r.rdata  = rd_val[31:0];
            next_r.rresp  = rd_val[32] ? RESP_OKAY : RESP_SLVERR;
        end

        // (RQ7) history; a new event beats a clear
        next_r.hist  = next_r.hist | f_rise;
        next_r.rec_p = |f_rise;

        case (r.st)
            ST_IDLE: begin
                next_r.dly = '0;
                // (RQ1) entry and count
                if (enter) begin
                    next_r.st = ST_RUN;
                    // (RQ2) trial does not count
                    if (!trial) begin
                        next_r.count = r.count + 16'h1;
                    end
                end
            end
            ST_RUN, ST_DECEL: begin
                // (RQ12) hard stop faults
                if (|f_stop) begin
                    next_r.st = ST_HALT;
                // (RQ9) restart class
                end else if (|f_rst) begin
                    // (RQ2) trial halts
                    if (trial) begin
                        next_r.st = ST_HALT;
                    end else begin
                        next_r.st      = ST_RETRY;
                        next_r.reset_p = 1'b1;
                        next_r.dly     = '0;
                    end
                end else if (r.st == ST_RUN) begin
                    // (RQ6) decelerate
                    if (!req) begin
                        next_r.st = ST_DECEL;
                    end
                end else if (enter) begin
                    next_r.st = ST_RUN;
                    if (!trial) begin
                        next_r.count = r.count + 16'h1;
                    end
                end else if (rif.at_target) begin
                    next_r.st = ST_IDLE;
                end
            end
            ST_RETRY: begin
                if (|f_stop) begin
                    next_r.st = ST_HALT;
                end else if (!req) begin
                    next_r.st = ST_IDLE;
                // (RQ11) retry delay in ticks
                end else if (r.dly >= r.retry) begin
                    next_r.dly = '0;
                    // (RQ10) no attempt limit
                    if (|f_rst) begin
                        next_r.reset_p = 1'b1;
                    end else begin
                        next_r.st = ST_RUN;
                    end
                end else if (r.tick) begin
                    next_r.dly = r.dly + 16'h1;
                end
            end
            ST_HALT: begin
                // Held until request and faults clear
                if (!req && !(|f_stop) && !(|f_rst)) begin
                    next_r.st = ST_IDLE;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase

        // (RQ3) override frequency source
        next_r.out_freq = active ? rif.level : normal_freq;
        // (RQ4) direction from setting
        next_r.out_dir  = active ? r.dir : normal_dir;
        next_r.out_run  = (r.st == ST_RUN) || (r.st == ST_DECEL) || (!active && normal_run);
        // (RQ7) hidden trips
        // (RQ8) ignored faults
        next_r.out_trip = active ? (r.st == ST_HALT) : (|fault_in);
    end

    // (RQ5) ramp up
    assign rif.tick     = r.tick;
    assign rif.target   = (r.st == ST_RUN) ? r.freq : 7'h00;
    assign rif.acc_time = r.acc;
    // (RQ6) ramp down
    assign rif.dec_time = r.dec;
    assign rif.drop     = (r.st == ST_IDLE) || (r.st == ST_RETRY) || (r.st == ST_HALT);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r        <= '0;
            r.st     <= ST_IDLE;
            r.mode   <= MODE_RST;
            r.dir    <= DIR_RST;
            r.termfn <= TERMFN_RST;
            r.freq   <= FREQ_RST;
            r.acc    <= ACC_RST;
            r.dec    <= DEC_RST;
            r.retry  <= RETRY_RST;
        end else begin
            r <= next_r;
        end
    end

    // One write and one read at a time
    assign s_axi_awready = !r.aw_got && !r.bvalid;
    assign s_axi_wready  = !r.w_got && !r.bvalid;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;

    assign freq_ref      = r.out_freq;
    assign run_dir       = r.out_dir;
    assign run_enable    = r.out_run;
    assign emerg_active  = active;
    assign trip_out      = r.out_trip;
    assign fault_reset   = r.reset_p;
    assign fault_record  = r.rec_p;

endmodule // ers_supervisor

// *** ers_supervisor_monitor.sv ***
/* Checker on the supervisor's drive-side ports.
   Assumes TICK_LEN of a few cycles or more. */
`timescale 1ns/1ps
module ers_supervisor_monitor import ers_pkg::*; (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [17:0] fault_in,
    input wire logic [6:0]  freq_ref,
    input wire logic        run_dir,
    input wire logic        run_enable,
    input wire logic        emerg_active,
    input wire logic        trip_out,
    input wire logic        fault_reset,
    input wire logic        fault_record
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Hard faults settle for three cycles
    property p_ign;
        emerg_active && !trip_out && !(|(fault_in & ~FAULT_IGN)) && !(|($past(fault_in) & ~FAULT_IGN))
            && !(|($past(fault_in, 2) & ~FAULT_IGN)) |=> !trip_out;
    endproperty
    property p_stop;
        emerg_active && |(fault_in & FAULT_STOP) |-> ##[1:3] (trip_out && !run_enable);
    endproperty
    property p_rst;
        emerg_active && run_enable && $rose(|(fault_in & FAULT_RESTART)) && !(|(fault_in & FAULT_STOP))
            |-> ##[1:3] (fault_reset || trip_out);
    endproperty
    property p_gap;
        fault_reset |=> !fault_reset [*8];
    endproperty
    property p_entry;
        $rose(emerg_active) && !(|fault_in) |=> run_enable && freq_ref <= 7'h01;
    endproperty
    property p_step;
        emerg_active && $past(emerg_active, 2) |-> {1'h0, freq_ref} <= {1'h0, $past(freq_ref)} + 8'h01;
    endproperty
    property p_max;
        emerg_active && $past(emerg_active, 2) |-> freq_ref <= FREQ_MAX;
    endproperty
    property p_dir;
        emerg_active && run_enable && $past(run_enable) && $past(emerg_active, 3) |-> $stable(run_dir);
    endproperty
    property p_rec;
        |(fault_in & ~$past(fault_in)) |-> ##[1:2] fault_record;
    endproperty
    a_ign: assert property (p_ign) else $error("ignored fault raised trip");
    a_stop: assert property (p_stop) else $error("no halt");
    a_rst: assert property (p_rst) else $error("no restart reset");
    a_gap: assert property (p_gap) else $error("resets too close");
    a_entry: assert property (p_entry) else $error("bad entry");
    a_step: assert property (p_step) else $error("reference jump");
    a_max: assert property (p_max) else $error("reference above limit");
    a_dir: assert property (p_dir) else $error("direction changed");
    a_rec: assert property (p_rec) else $error("fault not recorded");
    c_entry: cover property ($rose(emerg_active));
    c_retry: cover property (fault_reset ##[1:60] fault_reset);
    c_halt: cover property (emerg_active && trip_out);
endmodule // ers_supervisor_monitor

bind ers_supervisor ers_supervisor_monitor u_mon (.clk, .rst_n, .fault_in, .freq_ref, .run_dir,
    .run_enable, .emerg_active, .trip_out, .fault_reset, .fault_record);

// *** ers_drive_model.sv ***
/* Drive-side fault model.
   Assumes cond changes on clk; restart trips latch until a reset request. */
`timescale 1ns/1ps
module ers_drive_model import ers_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [17:0] cond,
    input  wire logic        fault_reset,
    output logic      [17:0] fault_in
);
    logic [17:0] trip_latch;
    // trip clears only on reset request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_latch <= 18'h00000;
        end else if (fault_reset) begin
            trip_latch <= cond & FAULT_RESTART;
        end else begin
            trip_latch <= trip_latch | (cond & FAULT_RESTART);
        end
    end
    assign fault_in = (cond & ~FAULT_RESTART) | trip_latch;
endmodule // ers_drive_model

// *** ers_supervisor_tb.sv ***
/* Self-checking bench for the supervisor.
   Assumes drive model and monitor compiled with it. */
`timescale 1ns/1ps
module ers_supervisor_tb import ers_pkg::*;;
    logic        clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    logic        nd = 1'h0, nr = 1'h0, awr, wrdy, bv, arr, rv, rdir, ren, emg, trip, frst, frec;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, seed = 32'h9206;
    logic [6:0]  nf = 7'h00, fref;
    logic [4:0]  term = 5'h00;
    logic [17:0] cond = 18'h0, fin;
    logic [1:0]  bresp, rresp;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          n_errors = 0, n_tests = 0, pulses;
    localparam logic [33:0] OK = {RESP_OKAY, 32'h0};

    always #4 clk = ~clk;

    ers_supervisor #(.TICK_LEN(10)) u_dut (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .multifunction_input_terminal(term), .fault_in(fin),
        .normal_freq(nf), .normal_dir(nd), .normal_run(nr), .freq_ref(fref), .run_dir(rdir), .run_enable(ren),
        .emerg_active(emg), .trip_out(trip), .fault_reset(frst), .fault_record(frec));
    ers_drive_model u_drv (.clk(clk), .rst_n(rst_n), .cond(cond), .fault_reset(frst), .fault_in(fin));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Noise on normal refs
    always @(posedge clk) begin
        seed = xs(seed);
        nf <= seed[6:0];
        nd <= seed[7];
        nr <= seed[8];
    end

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
        @(posedge clk);
        if (w) begin
            bq.push_back(e[33:32]);
            awa <= a;
            wd <= d;
            awv <= 1'h1;
            wv <= 1'h1;
            br <= 1'h1;
        end else begin
            rq.push_back(e);
            ara <= a;
            arv <= 1'h1;
            rr <= 1'h1;
        end
        // Readies seen at the edge, before the design updates
        do begin
            @(posedge clk);
            if (awr) awv <= 1'h0;
            if (wrdy) wv <= 1'h0;
            if (arr) arv <= 1'h0;
        end while (!((bv && br) || (rv && rr)));
        br <= 1'h0;
        rr <= 1'h0;
    endtask

    always @(posedge clk) begin
        if (bv && br) chk({bresp, 32'h0}, {bq.pop_front(), 32'h0});
        if (rv && rr) chk({rresp, rdat}, rq.pop_front());
    end

    task automatic wait_freq(input logic [6:0] f);
        for (int i = 0; i < 3000 && fref !== f; i++) @(negedge clk);
    endtask

    task automatic set_in(input logic [4:0] t, input logic [17:0] c);
        @(posedge clk);
        term <= t;
        cond <= c;
    endtask

    task automatic count_resets(input int n);
        pulses = 0;
        repeat (n) begin
            @(negedge clk);
            pulses += int'(frst);
        end
    endtask

    task automatic close_out;
        $display("Tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_errors++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        bus(0, ADDR_FREQ, 0, {RESP_OKAY, 32'h3C});
        bus(0, ADDR_RETRY, 0, {RESP_OKAY, 32'h3E8});
        bus(1, 8'h40, 32'h1, {RESP_SLVERR, 32'h0});
        bus(0, 8'h40, 0, {RESP_SLVERR, 32'h0});
        bus(1, ADDR_COUNT, 32'h5, OK);
        bus(0, ADDR_COUNT, 0, OK);
        bus(1, ADDR_FREQ, 32'h50, OK);
        bus(0, ADDR_FREQ, 0, {RESP_OKAY, 32'h3C});
        bus(1, ADDR_FREQ, 32'h5, OK);
        bus(1, ADDR_ACC, 32'h0, OK);
        bus(1, ADDR_DEC, 32'h0, OK);
        bus(1, ADDR_RETRY, 32'h2, OK);
        bus(1, ADDR_TERMFN, 32'h33000, OK);
        bus(1, ADDR_CTRL, 32'h5, OK);
        set_in(5'h04, 18'h0);
        wait_freq(7'h05);
        chk({rdir, fref}, {1'h1, 7'h05});
        bus(0, ADDR_COUNT, 0, {RESP_OKAY, 32'h1});
        for (int b = 0; b < 13; b++) begin
            set_in(5'h04, 18'h1 << b);
            repeat (20) @(negedge clk);
            chk({trip, ren, emg}, 3'h3);
        end
        set_in(5'h04, 18'h0);
        bus(0, ADDR_HIST, 0, {RESP_OKAY, 32'h1FFF});
        for (int b = 13; b < 16; b++) begin
            set_in(5'h04, 18'h1 << b);
            count_resets(200);
            chk(pulses >= 2, 1'h1);
            set_in(5'h04, 18'h0);
            wait_freq(7'h05);
            chk(fref, 7'h05);
        end
        for (int b = 16; b < 18; b++) begin
            set_in(5'h04, 18'h1 << b);
            repeat (6) @(negedge clk);
            chk({trip, ren}, 2'h2);
            set_in(5'h00, 18'h0);
            for (int i = 0; i < 3000 && emg !== 1'h0; i++) @(negedge clk);
            set_in(5'h04, 18'h0);
            wait_freq(7'h05);
        end
        set_in(5'h00, 18'h0);
        repeat (10) @(negedge clk);
        chk(emg, 1'h1);
        for (int i = 0; i < 3000 && emg !== 1'h0; i++) @(negedge clk);
        chk(emg, 1'h0);
        bus(1, ADDR_CTRL, 32'h2, OK);
        set_in(5'h04, 18'h0);
        wait_freq(7'h05);
        chk(rdir, 1'h0);
        set_in(5'h04, 18'h04000);
        count_resets(60);
        chk({trip, pulses[7:0]}, 9'h100);
        bus(0, ADDR_COUNT, 0, {RESP_OKAY, 32'h3});
        close_out();
    end
endmodule // ers_supervisor_tb
